//--- logic/tcam_rule_tables.sv
/*
 file: prefix-match and egress rule tables, staging cache, update control.
 assumes: register master on clk, lookup keys from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE1] prefix table 1024 addresses, 36 entry, 70 action
// [RULE2] one-bit saturating counter; spans 1,2,4,8 addresses
// [RULE3] first address tag encodes span
// [RULE4] continuation addresses carry zero tag bits
// [RULE5] prefix action words hold no tag
// [RULE6] entry bits spread after tag bits
// [RULE7] no default rules; no match means miss
// [RULE8] egress table 512 addresses, 30/285 bits, counter
// [RULE9] egress table single address, no tags
// [RULE10] eleven egress defaults at 512 plus n
// [RULE11] classifier rules aligned inside own range
// [RULE12] software writes only free addresses
// [RULE13] unused top entry bits match zero
// [RULE14] unused top action bits written zero
// [RULE15] software writes highest offset first
// [RULE16] cache untouched while update is busy
// [RULE17] clear bit wipes entry, mask, action, counter
// [RULE18] cleared cache means match-off, zero action
// [RULE19] action words: word 0 in low bits
// [RULE20] command 4 with address shifted three copies
// [RULE21] busy set on command, cleared after copy
module tcam_rule_tables (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output var logic [31:0] rdata,
	// prefix lookup
	input wire logic pm_key_valid,
	input wire logic [tcam_rule_pkg::PM_KEY_W-1:0] pm_key,
	input wire logic [1:0] pm_key_size,
	output var logic pm_result_valid,
	output var logic pm_hit,
	output var logic [9:0] pm_hit_addr,
	output var logic [tcam_rule_pkg::PM_ACT_W-1:0] pm_action,
	// egress lookup
	input wire logic eg_key_valid,
	input wire logic [tcam_rule_pkg::EG_ENT_W-1:0] eg_key,
	input wire logic [3:0] eg_default_sel,
	output var logic eg_result_valid,
	output var logic eg_hit,
	output var logic eg_default_hit,
	output var logic [9:0] eg_hit_addr,
	output var logic [tcam_rule_pkg::EG_ACT_W-1:0] eg_action
);
	import tcam_rule_pkg::*;

	// ****************
	// state
	// ****************
	typedef struct packed {
		logic [PM_DEPTH-1:0][PM_ENT_W-1:0] pm_data; // entry bits
		logic [PM_DEPTH-1:0][PM_ENT_W-1:0] pm_mask; // 1 = don't care
		logic [PM_DEPTH-1:0][PM_ACT_W-1:0] pm_act;
		logic [PM_DEPTH-1:0] pm_en; // 0 = match-off
		logic [PM_DEPTH-1:0] pm_cnt;
		logic [EG_ROWS-1:0][EG_ENT_W-1:0] eg_data;
		logic [EG_ROWS-1:0][EG_ENT_W-1:0] eg_mask;
		logic [EG_ROWS-1:0][EG_ACT_W-1:0] eg_act;
		logic [EG_ROWS-1:0] eg_en;
		logic [EG_ROWS-1:0] eg_cnt;
		logic [63:0] c_data; // cache, word 0 in low bits
		logic [63:0] c_mask;
		logic [32*ACT_WORDS-1:0] c_act;
		logic c_en;
		logic c_cnt;
		logic busy; // update_trigger_busy
		logic tgt; // 1 = egress table
		logic [CTRL_ADDR_W-1:0] taddr;
		logic [1:0] cmd;
		logic [2:0] wait_cnt;
		logic blk_on; // prefix block assigned
		logic [31:0] rdata;
		logic pm_result_valid;
		logic pm_hit;
		logic [9:0] pm_hit_addr;
		logic [PM_ACT_W-1:0] pm_action;
		logic eg_result_valid;
		logic eg_hit;
		logic eg_default_hit;
		logic [9:0] eg_hit_addr;
		logic [EG_ACT_W-1:0] eg_action;
	} state_t;

	state_t st; // registered state
	state_t next_st; // next state
	logic [PM_MAX_SPAN-1:0][PM_ENT_W-1:0] pm_words; // key laid out per offset
	logic pm_ok; // candidate still matching
	logic pm_found;
	logic eg_found;
	logic [3:0] act_idx; // addressed action word
	logic [4:0] span; // addresses per prefix entry

	// ****************
	// helpers
	// ****************
	// tag width at an offset for a given span
	function automatic int tag_w(input logic [1:0] sz, input int o);
		if (o == 0) begin
			return int'(sz) + 1;
		end
		if (o % 2 == 1) begin
			return 1;
		end
		return (o == 4) ? 3 : 2;
	endfunction

	// stored word expected for key slice at offset o
	function automatic logic [PM_ENT_W-1:0] pm_word(input logic [1:0] sz, input int o,
			input logic [PM_KEY_W-1:0] k);
		int b;
		logic [PM_ENT_W-1:0] r;
		b = 0;
		for (int i = 0; i < PM_MAX_SPAN; i++) begin
			if (i < o) begin
				b = b + PM_ENT_W - tag_w(sz, i); // [RULE6]
			end
		end
		r = PM_ENT_W'(k >> b) << tag_w(sz, o);
		// first address names the span, others stay zero
		if (o == 0) begin
			r[sz] = 1'b1; // [RULE3] [RULE4]
		end
		return r;
	endfunction

	// ternary compare of one address, disabled rows never match
	function automatic logic cell_ok(input logic [PM_ENT_W-1:0] d, input logic [PM_ENT_W-1:0] m,
			input logic [PM_ENT_W-1:0] w, input logic en);
		return en && (((d ^ w) & ~m) == '0); // [RULE18]
	endfunction

	// word-aligned action cache address
	function automatic logic is_act(input logic [7:0] a);
		return (a >= OFF_ACT0) && (a < OFF_ACT_END) && (a[1:0] == 2'h0);
	endfunction

	// ****************
	// next state
	// ****************
	// one process for registers, update engine and both lookups
	always_comb begin
		next_st = st;
		pm_words = '0;
		pm_ok = 1'b0;
		pm_found = 1'b0;
		eg_found = 1'b0;
		act_idx = 4'(8'(addr - OFF_ACT0) >> 2);
		span = 5'h1 << pm_key_size;
		next_st.rdata = '0;
		next_st.pm_result_valid = 1'b0;
		next_st.eg_result_valid = 1'b0;
		// register reads, data valid in the next cycle only
		if (re) begin
			case (addr)
				OFF_CTRL_SHARED, OFF_CTRL_EGRESS: begin
					next_st.rdata[CTRL_SHOT_BIT] = st.busy;
					next_st.rdata[CTRL_ADDR_LO +: CTRL_ADDR_W] = st.taddr;
					next_st.rdata[1:0] = st.cmd;
				end
				OFF_ENT0: next_st.rdata = st.c_data[31:0];
				OFF_ENT1: next_st.rdata = st.c_data[63:32];
				OFF_MSK0: next_st.rdata = st.c_mask[31:0];
				OFF_MSK1: next_st.rdata = st.c_mask[63:32];
				OFF_RULE: next_st.rdata[1:0] = {st.c_cnt, st.c_en};
				OFF_CONFIG: next_st.rdata[CONFIG_BLK_BIT] = st.blk_on;
				default: begin
					// unmapped addresses read zero
					if (is_act(addr)) begin
						next_st.rdata = st.c_act[32*act_idx +: 32];
					end
				end
			endcase
		end
		// config is not part of the cache, always writable
		if (we && addr == OFF_CONFIG) begin
			next_st.blk_on = wdata[CONFIG_BLK_BIT];
		end
		// cache and control writes are dropped while busy
		if (we && !st.busy) begin // [RULE16]
			case (addr)
				OFF_ENT0: next_st.c_data[31:0] = wdata;
				OFF_ENT1: next_st.c_data[63:32] = wdata;
				OFF_MSK0: next_st.c_mask[31:0] = wdata;
				OFF_MSK1: next_st.c_mask[63:32] = wdata;
				OFF_RULE: {next_st.c_cnt, next_st.c_en} = wdata[1:0];
				OFF_CTRL_SHARED, OFF_CTRL_EGRESS: begin
					// clear first, so clear plus shot copies an empty rule
					if (wdata[CTRL_CLEAR_BIT]) begin
						next_st.c_data = '0; // [RULE17] [RULE18]
						next_st.c_mask = '0;
						next_st.c_act = '0;
						next_st.c_en = 1'b0;
						next_st.c_cnt = 1'b0;
					end
					if (wdata[CTRL_SHOT_BIT]) begin
						next_st.busy = 1'b1; // [RULE20] [RULE21]
						next_st.tgt = (addr == OFF_CTRL_EGRESS);
						next_st.taddr = wdata[CTRL_ADDR_LO +: CTRL_ADDR_W];
						next_st.cmd = wdata[1:0];
						next_st.wait_cnt = XFER_CYCLES - 3'h1;
					end
				end
				default: begin
					if (is_act(addr)) begin
						next_st.c_act[32*act_idx +: 32] = wdata; // [RULE19]
					end
				end
			endcase
		end
		// update engine: busy drops in the same cycle the table takes the copy
		if (st.busy) begin
			if (st.wait_cnt == 3'h0) begin
				next_st.busy = 1'b0; // [RULE21]
				if (st.cmd == CMD_WRITE && !st.tgt) begin
					next_st.pm_data[st.taddr] = st.c_data[PM_ENT_W-1:0]; // [RULE1]
					next_st.pm_mask[st.taddr] = st.c_mask[PM_ENT_W-1:0];
					next_st.pm_act[st.taddr] = st.c_act[PM_ACT_W-1:0]; // [RULE5]
					next_st.pm_en[st.taddr] = st.c_en;
					next_st.pm_cnt[st.taddr] = st.c_cnt;
				end
				// addresses past the default rows are silently ignored
				if (st.cmd == CMD_WRITE && st.tgt && 32'(st.taddr) < EG_ROWS) begin
					next_st.eg_data[st.taddr] = st.c_data[EG_ENT_W-1:0]; // [RULE8] [RULE9]
					next_st.eg_mask[st.taddr] = st.c_mask[EG_ENT_W-1:0];
					next_st.eg_act[st.taddr] = st.c_act[EG_ACT_W-1:0];
					next_st.eg_en[st.taddr] = st.c_en;
					next_st.eg_cnt[st.taddr] = st.c_cnt;
				end
			end else begin
				next_st.wait_cnt = st.wait_cnt - 3'h1;
			end
		end
		// prefix lookup, lowest aligned start address wins
		if (pm_key_valid) begin
			for (int o = 0; o < PM_MAX_SPAN; o++) begin
				pm_words[o] = pm_word(pm_key_size, o, pm_key); // [RULE13]
			end
			for (int a = 0; a < PM_DEPTH; a++) begin
				pm_ok = st.blk_on && !pm_found && (a % int'(span) == 0); // [RULE7]
				for (int o = 0; o < PM_MAX_SPAN; o++) begin
					if (o < int'(span) && a + o < PM_DEPTH) begin
						pm_ok = pm_ok && cell_ok(st.pm_data[a+o], st.pm_mask[a+o],
							pm_words[o], st.pm_en[a+o]); // [RULE2]
					end
				end
				if (pm_ok) begin
					pm_found = 1'b1;
					next_st.pm_hit_addr = 10'(a);
				end
			end
			next_st.pm_result_valid = 1'b1;
			next_st.pm_hit = pm_found; // [RULE7]
			if (pm_found) begin
				next_st.pm_action = st.pm_act[next_st.pm_hit_addr];
				next_st.pm_cnt[next_st.pm_hit_addr] = 1'b1; // [RULE2]
			end else begin
				next_st.pm_hit_addr = '0;
				next_st.pm_action = '0;
			end
		end
		// egress lookup, entries first then the chosen default
		if (eg_key_valid) begin
			for (int a = 0; a < EG_DEPTH; a++) begin
				if (!eg_found && st.eg_en[a] &&
						(((st.eg_data[a] ^ eg_key) & ~st.eg_mask[a]) == '0)) begin
					eg_found = 1'b1;
					next_st.eg_hit_addr = 10'(a);
				end
			end
			next_st.eg_result_valid = 1'b1;
			next_st.eg_hit = eg_found;
			next_st.eg_default_hit = 1'b0;
			if (!eg_found) begin
				next_st.eg_hit_addr = '0;
				if (32'(eg_default_sel) < EG_DEFAULTS) begin
					next_st.eg_default_hit = 1'b1; // [RULE10]
					next_st.eg_hit_addr = 10'(EG_DEPTH + int'(eg_default_sel));
				end
			end
			if (eg_found || next_st.eg_default_hit) begin
				next_st.eg_action = st.eg_act[next_st.eg_hit_addr];
				next_st.eg_cnt[next_st.eg_hit_addr] = 1'b1; // [RULE8]
			end else begin
				next_st.eg_action = '0;
			end
		end
	end

	// ****************
	// registers
	// ****************
	// synchronous reset empties every table: all rows match-off
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign pm_result_valid = st.pm_result_valid;
	assign pm_hit = st.pm_hit;
	assign pm_hit_addr = st.pm_hit_addr;
	assign pm_action = st.pm_action;
	assign eg_result_valid = st.eg_result_valid;
	assign eg_hit = st.eg_hit;
	assign eg_default_hit = st.eg_default_hit;
	assign eg_hit_addr = st.eg_hit_addr;
	assign eg_action = st.eg_action;

	// ****************
	// checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_busy_set: assert property ( // [RULE21]
		we && !st.busy && addr == OFF_CTRL_SHARED && wdata[CTRL_SHOT_BIT]
		|=> st.busy [*4] ##1 !st.busy) else $error("busy length wrong");
	a_cache_clear: assert property ( // [RULE17]
		we && !st.busy && addr == OFF_CTRL_EGRESS && wdata[CTRL_CLEAR_BIT]
		|=> st.c_act == '0 && st.c_data == '0 && !st.c_cnt) else $error("cache not cleared");
	a_cache_lock: assert property ( // [RULE16]
		st.busy |=> $stable(st.c_act) && $stable(st.c_data)) else $error("cache changed");
	a_pm_copy: assert property ( // [RULE20]
		$fell(st.busy) && !st.tgt && st.cmd == CMD_WRITE
		|-> st.pm_act[st.taddr] == st.c_act[PM_ACT_W-1:0]) else $error("prefix copy lost");
	a_eg_copy: assert property ( // [RULE9]
		$fell(st.busy) && st.tgt && st.taddr == 10'h0d7
		|-> st.eg_data[215] == st.c_data[EG_ENT_W-1:0]) else $error("egress copy lost");
	a_pm_no_block: assert property ( // [RULE7]
		pm_key_valid && !st.blk_on |=> st.pm_result_valid && !st.pm_hit)
		else $error("hit without block");
	a_pm_counter: assert property ( // [RULE2]
		st.pm_result_valid && st.pm_hit |-> st.pm_cnt[st.pm_hit_addr])
		else $error("prefix counter not set");
	a_eg_default: assert property ( // [RULE10]
		eg_key_valid && eg_default_sel < 4'hb |=> st.eg_hit ||
		(st.eg_default_hit && st.eg_hit_addr == 10'h200 + 10'($past(eg_default_sel))))
		else $error("wrong default row");
	a_eg_counter: assert property ( // [RULE8]
		st.eg_result_valid && (st.eg_hit || st.eg_default_hit)
		|-> st.eg_cnt[st.eg_hit_addr]) else $error("egress counter not set");
	a_read_zero: assert property ( // [RULE19]
		!re |=> st.rdata == '0) else $error("read data outside slot");
endmodule // tcam_rule_tables
`default_nettype wire

//--- common/tcam_rule_pkg.sv
/*
 file: constants for the rule tables, their staging cache and the register map.
 assumes: 32-bit register port with byte-style word offsets.
*/
package tcam_rule_pkg;
	// ****************
	// register map
	// ****************
	localparam logic [7:0] OFF_CTRL_SHARED = 8'h00; // update control, shared table
	localparam logic [7:0] OFF_CTRL_EGRESS = 8'h04; // update control, egress table
	localparam logic [7:0] OFF_ENT0 = 8'h08; // cache entry data word 0
	localparam logic [7:0] OFF_ENT1 = 8'h0c; // cache entry data word 1
	localparam logic [7:0] OFF_MSK0 = 8'h10; // cache mask word 0
	localparam logic [7:0] OFF_MSK1 = 8'h14; // cache mask word 1
	localparam logic [7:0] OFF_ACT0 = 8'h18; // first action cache word
	localparam logic [7:0] OFF_ACT_END = 8'h3c; // one past the last action word
	localparam logic [7:0] OFF_RULE = 8'h3c; // cache enable and counter
	localparam logic [7:0] OFF_CONFIG = 8'h40; // resource assignment
	// ****************
	// field layout
	// ****************
	localparam int CTRL_SHOT_BIT = 2; // update_trigger_busy
	localparam int CTRL_ADDR_LO = 3; // target address field
	localparam int CTRL_ADDR_W = 10;
	localparam int CTRL_CLEAR_BIT = 31; // self-clearing cache clear
	localparam logic [1:0] CMD_WRITE = 2'h0; // copy cache into table
	localparam int RULE_EN_BIT = 0;
	localparam int RULE_CNT_BIT = 1;
	localparam int CONFIG_BLK_BIT = 0;
	// ****************
	// table geometry
	// ****************
	localparam int PM_DEPTH = 1024; // one resource block
	localparam int PM_ENT_W = 36;
	localparam int PM_ACT_W = 70;
	localparam int PM_MAX_SPAN = 8;
	localparam int PM_KEY_W = 273; // widest span: e[272:0]
	localparam int EG_DEPTH = 512;
	localparam int EG_DEFAULTS = 11;
	localparam int EG_ROWS = EG_DEPTH + EG_DEFAULTS;
	localparam int EG_ENT_W = 30;
	localparam int EG_ACT_W = 285;
	localparam int ACT_WORDS = 9;
	// ****************
	// timing
	// ****************
	localparam logic [2:0] XFER_CYCLES = 3'h4; // cycles a cache copy is busy
endpackage

//--- testbench/host_model.sv
/*
 host model: programs the rule tables over the register port.
 assumes: strobes taken on rising clk; busy lasts four cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock
	input wire logic clk,
	// register master
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic we,
	output logic re,
	// expectation beside each read
	output logic chk,
	output logic [31:0] exp_rd,
	output logic [31:0] exp_msk
);
	import tcam_rule_pkg::*;
	// ****
	// bus cycles
	// ****
	initial begin
		{addr, wdata, we, re, chk, exp_rd, exp_msk} = '0;
	end
	// one cycle; each signal assigned once per edge
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m);
		we <= w;
		re <= r;
		chk <= r;
		addr <= a;
		wdata <= d;
		exp_rd <= e;
		exp_msk <= m;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d, 32'h0, 32'h0);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, 1'b1, a, 32'h0, e, m);
	endtask
	task automatic idle();
		bus(1'b0, 1'b0, 8'h00, 32'h0, 32'h0, 32'h0);
	endtask
	// copy, then sit out the busy time
	task automatic cmd(input logic [7:0] off, input logic [9:0] row);
		wr(off, 32'h4 | (32'(row) << CTRL_ADDR_LO));
		rdc(off, 32'h4, 32'h4);
		// deliberate cache write while busy: must be dropped
		wr(OFF_ENT0, 32'hffffffff);
		rdc(off, 32'h4, 32'h4);
		rdc(off, 32'h4, 32'h4);
		rdc(off, 32'h0, 32'h4);
		idle();
	endtask
	// one address of a rule, from a cleared cache
	task automatic rule(input logic [7:0] off, input logic [9:0] row, input logic [35:0] ent,
		input logic [35:0] msk, input logic [287:0] act);
		wr(off, 32'h80000000);
		wr(OFF_ENT0, ent[31:0]);
		wr(OFF_ENT1, {28'h0, ent[35:32]});
		wr(OFF_MSK0, msk[31:0]);
		wr(OFF_MSK1, {28'h0, msk[35:32]});
		for (int i = 0; i < ACT_WORDS; i++) begin
			wr(OFF_ACT0 + 8'(4 * i), act[32 * i +: 32]);
		end
		wr(OFF_RULE, 32'h1);
		cmd(off, row);
	endtask
	// removal: copy a cleared cache over the row
	task automatic blank(input logic [7:0] off, input logic [9:0] row);
		wr(off, 32'h80000000);
		cmd(off, row);
	endtask
endmodule // host_model
`default_nettype wire

//--- testbench/testbench.sv
/*
 testbench: drives lookups, host model programs tables, queues checked.
 assumes: one-cycle lookup and read latency.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import tcam_rule_pkg::*;
	logic clk, srst, we, re, chk;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, exp_rd, exp_msk;
	logic pm_key_valid, pm_result_valid, pm_hit;
	logic [PM_KEY_W-1:0] pm_key;
	logic [1:0] pm_key_size;
	logic [9:0] pm_hit_addr, eg_hit_addr;
	logic [PM_ACT_W-1:0] pm_action;
	logic eg_key_valid, eg_result_valid, eg_hit, eg_default_hit;
	logic [EG_ENT_W-1:0] eg_key;
	logic [3:0] eg_default_sel;
	logic [EG_ACT_W-1:0] eg_action;
	int miscompares = 0;
	int n_compared = 0;
	int wid[4] = '{35, 69, 137, 273}; // key bits per span
	logic [63:0] rd_q[$];
	logic [80:0] pm_q[$];
	logic [296:0] eg_q[$];
	logic [63:0] note;
	logic rd_tag = 0;
	logic [31:0] seed = 32'd48167;
	tcam_rule_tables tcam_rule_tables_inst (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.we(we), .re(re), .rdata(rdata), .pm_key_valid(pm_key_valid), .pm_key(pm_key),
		.pm_key_size(pm_key_size), .pm_result_valid(pm_result_valid), .pm_hit(pm_hit),
		.pm_hit_addr(pm_hit_addr), .pm_action(pm_action), .eg_key_valid(eg_key_valid),
		.eg_key(eg_key), .eg_default_sel(eg_default_sel), .eg_result_valid(eg_result_valid),
		.eg_hit(eg_hit), .eg_default_hit(eg_default_hit), .eg_hit_addr(eg_hit_addr),
		.eg_action(eg_action));
	host_model host_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.chk(chk), .exp_rd(exp_rd), .exp_msk(exp_msk));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// tag width per offset
	function automatic int tgw(input int o, input int sz);
		if (o == 0) return sz + 1;
		if (o % 2 == 1) return 1;
		return (o == 4) ? 3 : 2;
	endfunction
	task automatic cmp(input string nm, input logic [296:0] e, input logic [296:0] s);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic pm_look(input logic [287:0] k, input int sz, input logic h, input int a,
		input logic [69:0] act);
		pm_key <= PM_KEY_W'(k);
		pm_key_size <= 2'(sz);
		pm_key_valid <= 1'b1;
		pm_q.push_back({h, 10'(a), act});
		@(posedge clk);
		pm_key_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic eg_look(input logic [29:0] k, input int sel, input logic h, input logic d,
		input int a, input logic [287:0] act);
		eg_key <= k;
		eg_default_sel <= 4'(sel);
		eg_key_valid <= 1'b1;
		eg_q.push_back({h, d, 10'(a), 285'(act)});
		@(posedge clk);
		eg_key_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic complete_run();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****
	// result watcher: notes taken on the edge, outputs read mid-cycle
	// ****
	always @(posedge clk) begin
		if (re === 1'b1 && chk === 1'b1) rd_q.push_back({exp_rd, exp_msk});
		rd_tag <= re & chk;
	end
	always @(negedge clk) begin
		if (rd_tag && rd_q.size() > 0) begin
			note = rd_q.pop_front();
			cmp("rdata", 297'(note[63:32] & note[31:0]), 297'(rdata & note[31:0]));
		end else cmp("idle rdata", 297'h0, 297'(rdata));
		if (pm_result_valid === 1'b1 && pm_q.size() > 0)
			cmp("prefix", 297'(pm_q.pop_front()), 297'({pm_hit, pm_hit_addr, pm_action}));
		if (eg_result_valid === 1'b1 && eg_q.size() > 0)
			cmp("egress", eg_q.pop_front(), {eg_hit, eg_default_hit, eg_hit_addr, eg_action});
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		complete_run();
	end
	// ****
	// main sequence
	// ****
	initial begin
		logic [287:0] ent, eact, dact;
		logic [69:0] act;
		logic [29:0] ek;
		int p, b;
		{srst, pm_key_valid, eg_key_valid, pm_key, pm_key_size, eg_key, eg_default_sel} = '1;
		{pm_key_valid, eg_key_valid} = 2'h0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		host_model_inst.rdc(OFF_CTRL_SHARED, 32'h0, 32'h4);
		host_model_inst.rdc(8'h44, 32'h0, 32'hffffffff);
		host_model_inst.idle();
		// every span, highest offset written first
		for (int sz = 0; sz < 4; sz++) begin
			b = 16 * (sz + 1);
			for (int i = 0; i < 9; i++) ent[32 * i +: 32] = xs();
			ent = ent & ~({288{1'b1}} << wid[sz]);
			act = 70'({xs(), xs(), xs()});
			for (int o = (1 << sz) - 1; o >= 0; o--) begin
				p = 0;
				for (int j = 0; j < o; j++) p += 36 - tgw(j, sz);
				host_model_inst.rule(OFF_CTRL_SHARED, 10'(b + o), (36'(ent >> p) << tgw(o, sz))
					| ((o == 0) ? 36'(1 << sz) : 36'h0), 36'h0, (o == 0) ? 288'(act) : 288'h0);
			end
			if (sz == 0) begin
				pm_look(ent, sz, 1'b0, 0, 70'h0);
				host_model_inst.wr(OFF_CONFIG, 32'h1);
				host_model_inst.idle();
			end
			pm_look(ent, sz, 1'b1, b, act);
			pm_look(ent ^ (288'h1 << (wid[sz] - 1)), sz, 1'b0, 0, 70'h0);
		end
		// egress rule, then a blank row below it
		ek = 30'(xs());
		for (int i = 0; i < 9; i++) eact[32 * i +: 32] = xs();
		for (int i = 0; i < 9; i++) dact[32 * i +: 32] = xs();
		eact[287:285] = 3'h0;
		dact[287:285] = 3'h0;
		host_model_inst.rule(OFF_CTRL_EGRESS, 10'd215, 36'(ek), 36'h0, eact);
		host_model_inst.blank(OFF_CTRL_EGRESS, 10'd100);
		eg_look(ek, 11, 1'b1, 1'b0, 215, eact);
		host_model_inst.rule(OFF_CTRL_EGRESS, 10'd520, 36'h0, 36'h0, dact);
		eg_look(ek ^ 30'h1, 8, 1'b0, 1'b1, 520, dact);
		eg_look(ek ^ 30'h1, 3, 1'b0, 1'b1, 515, 288'h0);
		eg_look(ek ^ 30'h1, 11, 1'b0, 1'b0, 0, 288'h0);
		host_model_inst.blank(OFF_CTRL_EGRESS, 10'd215);
		eg_look(ek, 3, 1'b0, 1'b1, 515, 288'h0);
		repeat (4) @(posedge clk);
		if (rd_q.size() + pm_q.size() + eg_q.size() != 0) miscompares++;
		complete_run();
	end
endmodule // testbench
`default_nettype wire
